// ==== hw/mtw_defines.svh ====
// offsets, field positions, reset values and fixed figures for the
// message target window control block; definitions only.
`ifndef MTW_DEFINES_SVH
`define MTW_DEFINES_SVH

// register offsets (byte addresses, low 12 bits decoded)
`define MTW_OFF_CTL        12'h500
`define MTW_OFF_XLATE      12'h504
`define MTW_OFF_BASE       12'h510
`define MTW_OFF_STATUS     12'h514

// control register fields
`define MTW_CTL_WINDOW_ON  31
`define MTW_CTL_SUBST_ON   30
`define MTW_CTL_BAR_VIS    29
`define MTW_CTL_SIZE_HI    27
`define MTW_CTL_SIZE_LO    24
`define MTW_CTL_RDC_HI     20
`define MTW_CTL_RDC_LO     16
`define MTW_CTL_GLOBAL     15
`define MTW_CTL_NOCACHE    14
`define MTW_CTL_WRC_HI     12
`define MTW_CTL_WRC_LO     8
`define MTW_CTL_RETAIN     7
`define MTW_CTL_END_HI     6
`define MTW_CTL_END_LO     5
`define MTW_CTL_ALIAS      4
`define MTW_CTL_AMT_HI     2
`define MTW_CTL_AMT_LO     0
`define MTW_CTL_RESET      32'h000a_0240
`define MTW_CTL_WMASK      32'hef1f_dff7

// upper 16 bits hold base and translated address
`define MTW_UPPER_MASK     32'hffff_0000
`define MTW_MIN_SIZE_LOG2  16
`define MTW_SHELL_LIMIT    32'h0000_1000
`define MTW_SHELL_BYTES    8'h08
`define MTW_MIN_BYTES      8'h08
`define MTW_MAX_AMT        3'h4
`define MTW_END_BIG        2'h2
`define MTW_END_ADDR_LE    2'h1
`define MTW_BUF_WORDS      32
`define MTW_RESP_OKAY      2'h0
`define MTW_RESP_SLVERR    2'h2

`endif

// ==== hw/mtw_pkg.sv ====
// types shared by the message target window control block.
// assumes mtw_defines.svh sits on the include path.
package mtw_pkg;

  typedef struct packed {
    logic        write;
    logic        multiple;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mtw_pci_req_t;

  typedef struct packed {
    logic        claimed;
    logic        shell;
    logic [31:0] rdata;
  } mtw_pci_rsp_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [4:0]  txn_code;
    logic        pbus_global_pin_n;
    logic        pbus_cache_inhibit_pin_n;
    logic [7:0]  bytes;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mtw_pbus_req_t;

  typedef enum logic [2:0] {
    MTW_IDLE,
    MTW_DECODE,
    MTW_ISSUE,
    MTW_FILL,
    MTW_PEEK,
    MTW_ANSWER
  } mtw_state_t;

endpackage

// ==== hw/mtw_prefetch_mem.sv ====
// prefetch data store: one write port, one read port, registered read.
// assumes writer and reader share clk; no reset on the array.
`timescale 1ns/1ns
module mtw_prefetch_mem (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [4:0]  rd_idx,
  output logic      [31:0] rd_data
);
  logic [31:0] words [0:31];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      words[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= words[rd_idx];
  end
endmodule

// ==== hw/mtw_ctl.sv ====
// message target window control: claims window memory cycles, steers
// them to the processor bus, and keeps prefetched read data.
// assumes pci and processor bus request logic run on clk; registers
// reached over axi4-lite.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "mtw_defines.svh"
module mtw_ctl (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [31:0]            s_awaddr,
  input  wire logic                   s_awvalid,
  output logic                        s_awready,
  input  wire logic [31:0]            s_wdata,
  input  wire logic [3:0]             s_wstrb,
  input  wire logic                   s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire logic                   s_bready,
  input  wire logic [31:0]            s_araddr,
  input  wire logic                   s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire logic                   s_rready,
  input  wire logic                   cfg_load,
  input  wire logic                   cfg_bar_visible,
  input  wire logic [3:0]             cfg_size_code,
  input  wire logic                   pci_req_valid,
  output logic                        pci_req_ready,
  input  wire mtw_pkg::mtw_pci_req_t  pci_req,
  output logic                        pci_rsp_valid,
  output mtw_pkg::mtw_pci_rsp_t       pci_rsp,
  output logic                        pbus_req_valid,
  input  wire logic                   pbus_req_ready,
  output mtw_pkg::mtw_pbus_req_t      pbus_req,
  input  wire logic                   pbus_rd_valid,
  input  wire logic [31:0]            pbus_rd_data
);
  function automatic logic [31:0] win_mask(input logic [3:0] code);
    win_mask = 32'hffff_ffff << (`MTW_MIN_SIZE_LOG2 + int'(code));
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
    lane_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        lane_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // little-endian modes swap lanes; the munged mode keeps lanes
  function automatic logic [31:0] conv_data(input logic [1:0]  mode,
                                            input logic [31:0] d);
    if (mode == `MTW_END_BIG || mode == `MTW_END_ADDR_LE) begin
      conv_data = d;
    end else begin
      conv_data = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction

  logic [31:0]         ctl;
  logic [31:0]         xlate;
  logic [31:0]         base;
  logic                base_written;
  logic                aw_held;
  logic                w_held;
  logic [31:0]         aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                do_write;
  mtw_pkg::mtw_state_t state;
  mtw_pkg::mtw_pci_req_t cur;
  logic [4:0]          fill_cnt;
  logic [5:0]          fill_words;
  logic [4:0]          rd_idx;
  logic [31:0]         mem_rdata;
  logic                buf_valid;
  logic [31:0]         buf_next;
  logic [4:0]          buf_idx;
  logic [5:0]          buf_words;
  logic                cur_hit;
  logic                cur_shell;
  logic                buf_hit;
  logic [31:0]         mask;
  logic [1:0]          end_mode;
  logic [7:0]          bytes;
  logic [31:0]         xaddr;
  logic [31:0]         base_wr_val;

  assign do_write = aw_held && w_held && !s_bvalid;
  assign mask     = win_mask(ctl[`MTW_CTL_SIZE_HI:`MTW_CTL_SIZE_LO]);
  assign cur_hit  = ctl[`MTW_CTL_WINDOW_ON] &&
                    ((cur.addr & mask) == (base & mask));
  assign cur_shell = (cur.addr & ~mask) < `MTW_SHELL_LIMIT;
  assign buf_hit  = buf_valid && (cur.addr == buf_next);
  assign end_mode = cur_shell ? `MTW_END_BIG
                  : ctl[`MTW_CTL_END_HI:`MTW_CTL_END_LO];
  assign base_wr_val = lane_merge(base, w_data, w_strb) & `MTW_UPPER_MASK;

  // translated address: with substitution on, the compared upper bits are replaced outside the shell, and bit 2 flips in address little-endian mode
  always_comb begin
    xaddr = cur.addr;
    if (ctl[`MTW_CTL_SUBST_ON] && !cur_shell) begin
      xaddr = (xlate & mask) | (cur.addr & ~mask);
    end
    if (end_mode == `MTW_END_ADDR_LE) begin
      xaddr = xaddr ^ 32'h0000_0004;
    end
  end

  // prefetch amount in bytes
  always_comb begin
    bytes = `MTW_MIN_BYTES;
    if (cur_shell) begin
      bytes = `MTW_SHELL_BYTES;
    end else if ((cur.multiple || ctl[`MTW_CTL_ALIAS]) &&
                 ctl[`MTW_CTL_AMT_HI:`MTW_CTL_AMT_LO] <= `MTW_MAX_AMT) begin
      bytes = `MTW_MIN_BYTES << ctl[`MTW_CTL_AMT_HI:`MTW_CTL_AMT_LO];
    end
  end

  // axi write address and data capture, either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held   <= 1'b0;
      s_awready <= 1'b1;
      aw_addr   <= 32'h0000_0000;
    end else if (s_awvalid && s_awready) begin
      aw_held   <= 1'b1;
      s_awready <= 1'b0;
      aw_addr   <= s_awaddr;
    end else if (do_write) begin
      aw_held   <= 1'b0;
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held   <= 1'b0;
      s_wready <= 1'b1;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_held   <= 1'b1;
      s_wready <= 1'b0;
      w_data   <= s_wdata;
      w_strb   <= s_wstrb;
    end else if (do_write) begin
      w_held   <= 1'b0;
      s_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= `MTW_RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      case (aw_addr[11:0])
        `MTW_OFF_CTL, `MTW_OFF_XLATE, `MTW_OFF_BASE,
        `MTW_OFF_STATUS: s_bresp <= `MTW_RESP_OKAY;
        default:         s_bresp <= `MTW_RESP_SLVERR;
      endcase
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // control register, window enable and configuration load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl <= `MTW_CTL_RESET;
    end else begin
      if (do_write && aw_addr[11:0] == `MTW_OFF_CTL) begin
        ctl <= lane_merge(ctl, w_data, w_strb) & `MTW_CTL_WMASK;
      end else if (do_write && aw_addr[11:0] == `MTW_OFF_BASE &&
                   ctl[`MTW_CTL_BAR_VIS]) begin
        if (base_wr_val == 32'h0000_0000) begin
          ctl[`MTW_CTL_WINDOW_ON] <= 1'b0;
        end else if (!base_written) begin
          ctl[`MTW_CTL_WINDOW_ON] <= 1'b1;
        end
      end
      if (cfg_load) begin
        ctl[`MTW_CTL_BAR_VIS] <= cfg_bar_visible;
        ctl[`MTW_CTL_SIZE_HI:`MTW_CTL_SIZE_LO] <= cfg_size_code;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xlate        <= 32'h0000_0000;
      base         <= 32'h0000_0000;
      base_written <= 1'b0;
    end else if (do_write) begin
      if (aw_addr[11:0] == `MTW_OFF_XLATE) begin
        xlate <= lane_merge(xlate, w_data, w_strb) & `MTW_UPPER_MASK;
      end
      if (aw_addr[11:0] == `MTW_OFF_BASE && ctl[`MTW_CTL_BAR_VIS]) begin
        base         <= base_wr_val;
        base_written <= 1'b1;
      end
    end
  end

  // axi read: answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= `MTW_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= `MTW_RESP_OKAY;
      case (s_araddr[11:0])
        `MTW_OFF_CTL:    s_rdata <= ctl;
        `MTW_OFF_XLATE:  s_rdata <= xlate;
        `MTW_OFF_BASE:   s_rdata <= ctl[`MTW_CTL_BAR_VIS] ? base
                                    : 32'h0000_0000;
        `MTW_OFF_STATUS: s_rdata <= {26'h000_0000, buf_valid,
                                     base_written, 1'b0, state};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= `MTW_RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // transaction sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= mtw_pkg::MTW_IDLE;
    end else begin
      case (state)
        mtw_pkg::MTW_IDLE:
          if (pci_req_valid && pci_req_ready) begin
            state <= mtw_pkg::MTW_DECODE;
          end
        mtw_pkg::MTW_DECODE:
          if (!cur_hit) begin
            state <= mtw_pkg::MTW_IDLE;
          end else if (!cur.write && buf_hit) begin
            state <= mtw_pkg::MTW_PEEK;
          end else begin
            state <= mtw_pkg::MTW_ISSUE;
          end
        mtw_pkg::MTW_ISSUE:
          if (pbus_req_ready) begin
            state <= cur.write ? mtw_pkg::MTW_IDLE : mtw_pkg::MTW_FILL;
          end
        mtw_pkg::MTW_FILL:
          if (pbus_rd_valid && {1'b0, fill_cnt} == fill_words - 6'h01) begin
            state <= mtw_pkg::MTW_PEEK;
          end
        mtw_pkg::MTW_PEEK:   state <= mtw_pkg::MTW_ANSWER;
        mtw_pkg::MTW_ANSWER: state <= mtw_pkg::MTW_IDLE;
        default:             state <= mtw_pkg::MTW_IDLE;
      endcase
    end
  end

  // pci side handshake and answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pci_req_ready <= 1'b1;
      pci_rsp_valid <= 1'b0;
      pci_rsp       <= '0;
      cur           <= '0;
    end else begin
      pci_rsp_valid <= 1'b0;
      if (state == mtw_pkg::MTW_IDLE && pci_req_valid && pci_req_ready) begin
        cur           <= pci_req;
        pci_req_ready <= 1'b0;
      end
      if (state == mtw_pkg::MTW_DECODE && !cur_hit) begin
        pci_rsp_valid <= 1'b1;
        pci_rsp       <= '0;
        pci_req_ready <= 1'b1;
      end
      if (state == mtw_pkg::MTW_ISSUE && pbus_req_ready && cur.write) begin
        pci_rsp_valid <= 1'b1;
        pci_rsp       <= '{claimed: 1'b1, shell: cur_shell, rdata: 32'h0};
        pci_req_ready <= 1'b1;
      end
      if (state == mtw_pkg::MTW_ANSWER) begin
        pci_rsp_valid <= 1'b1;
        pci_rsp <= '{claimed: 1'b1, shell: cur_shell,
                     rdata: conv_data(end_mode, mem_rdata)};
        pci_req_ready <= 1'b1;
      end
    end
  end

  // processor bus request, held until taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pbus_req_valid <= 1'b0;
      pbus_req       <= '0;
    end else if (state == mtw_pkg::MTW_DECODE && cur_hit &&
                 (cur.write || !buf_hit)) begin
      pbus_req_valid    <= 1'b1;
      pbus_req.write    <= cur.write;
      pbus_req.addr     <= xaddr;
      pbus_req.txn_code <= cur.write
                           ? ctl[`MTW_CTL_WRC_HI:`MTW_CTL_WRC_LO]
                           : ctl[`MTW_CTL_RDC_HI:`MTW_CTL_RDC_LO];
      pbus_req.pbus_global_pin_n <= ctl[`MTW_CTL_GLOBAL];
      pbus_req.pbus_cache_inhibit_pin_n <= ctl[`MTW_CTL_NOCACHE];
      pbus_req.bytes    <= cur.write ? 8'h04 : bytes;
      pbus_req.wdata    <= conv_data(end_mode, cur.wdata);
      pbus_req.be       <= cur.be;
    end else if (pbus_req_valid && pbus_req_ready) begin
      pbus_req_valid <= 1'b0;
    end
  end

  // fill count and prefetch bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill_cnt   <= 5'h00;
      fill_words <= 6'h00;
      rd_idx     <= 5'h00;
      buf_valid  <= 1'b0;
      buf_next   <= 32'h0000_0000;
      buf_idx    <= 5'h00;
      buf_words  <= 6'h00;
    end else begin
      case (state)
        mtw_pkg::MTW_DECODE:
          if (!cur.write) begin
            if (cur_hit && buf_hit) begin
              rd_idx <= buf_idx;
            end else begin
              buf_valid  <= 1'b0;
              fill_cnt   <= 5'h00;
              fill_words <= 6'(bytes >> 2);
              rd_idx     <= 5'h00;
            end
          end
        mtw_pkg::MTW_FILL:
          if (pbus_rd_valid) begin
            fill_cnt  <= fill_cnt + 5'h01;
            buf_words <= fill_words;
          end
        mtw_pkg::MTW_ANSWER: begin
          buf_valid <= ctl[`MTW_CTL_RETAIN] && !cur_shell &&
                       ({1'b0, rd_idx} + 6'h01 < buf_words);
          buf_next  <= cur.addr + 32'h0000_0004;
          buf_idx   <= rd_idx + 5'h01;
        end
        default: begin
        end
      endcase
    end
  end

  mtw_prefetch_mem u_mem (
    .clk     (clk),
    .wr_en   (state == mtw_pkg::MTW_FILL && pbus_rd_valid),
    .wr_idx  (fill_cnt),
    .wr_data (pbus_rd_data),
    .rd_idx  (rd_idx),
    .rd_data (mem_rdata)
  );

endmodule

// ==== tb/mtw_pbus_model.sv ====
// processor bus agent model for the message target window block.
// assumes one request at a time; read words follow the take.
`timescale 1ns/1ns
module mtw_pbus_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   slow,
  input  wire logic                   pbus_req_valid,
  input  wire mtw_pkg::mtw_pbus_req_t pbus_req,
  output logic                        pbus_req_ready,
  output logic                        pbus_rd_valid,
  output logic [31:0]                 pbus_rd_data,
  output mtw_pkg::mtw_pbus_req_t      last_req,
  output int                          n_req
);
  logic [7:0]  left;
  logic [31:0] a;
  int          w;
  always @(posedge clk) begin
    pbus_rd_valid <= 1'b0;
    // idle data line inverts every cycle, so it shows the last word only every other cycle
    pbus_rd_data <= ~pbus_rd_data;
    w <= w + 1;
    if (!rst_n) begin
      pbus_req_ready <= 1'b0;
      left <= 8'h00;
      n_req <= 0;
      w <= 0;
    end else if (pbus_req_valid && pbus_req_ready) begin
      pbus_req_ready <= 1'b0;
      last_req <= pbus_req;
      n_req <= n_req + 1;
      a <= pbus_req.addr;
      left <= pbus_req.write ? 8'h00 : pbus_req.bytes >> 2;
    end else if (left != 8'h00) begin
      if (!slow || w[0]) begin
        pbus_rd_valid <= 1'b1;
        pbus_rd_data <= a ^ 32'hc3c3_0000;
        a <= a + 32'h4;
        left <= left - 8'h01;
      end
    end else if (!slow || w[1:0] == 2'h3) begin
      pbus_req_ready <= 1'b1;
    end
  end
endmodule

// ==== tb/mtw_ctl_monitor.sv ====
// port monitor for the message target window control block.
// assumes whole-word register writes; bound into every mtw_ctl.
`timescale 1ns/1ns
module mtw_ctl_monitor (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [31:0]            s_awaddr,
  input wire logic                   s_awvalid,
  input wire logic                   s_awready,
  input wire logic [31:0]            s_wdata,
  input wire logic                   s_wvalid,
  input wire logic                   s_wready,
  input wire logic [1:0]             s_bresp,
  input wire logic                   s_bvalid,
  input wire logic                   s_bready,
  input wire logic                   cfg_load,
  input wire logic                   cfg_bar_visible,
  input wire logic [3:0]             cfg_size_code,
  input wire logic                   pci_req_valid,
  input wire logic                   pci_req_ready,
  input wire mtw_pkg::mtw_pci_req_t  pci_req,
  input wire logic                   pci_rsp_valid,
  input wire mtw_pkg::mtw_pci_rsp_t  pci_rsp,
  input wire logic                   pbus_req_valid,
  input wire logic                   pbus_req_ready,
  input wire mtw_pkg::mtw_pbus_req_t pbus_req
);
  logic [31:0] shd, awa, wd, pa, pba;
  logic [7:0]  pbb;
  logic        wr_q, mul_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow lags register writes by one edge, cfg loads land on the same edge; no pci traffic then
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shd <= 32'h000a_0240;
    end else begin
      if (s_bvalid && s_bready && s_bresp == 2'h0 && awa[11:0] == 12'h500)
        shd <= wd;
      if (cfg_load) begin
        shd[29] <= cfg_bar_visible;
        shd[27:24] <= cfg_size_code;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (s_awvalid && s_awready) awa <= s_awaddr;
    if (s_wvalid && s_wready) wd <= s_wdata;
    if (pci_req_valid && pci_req_ready) begin
      pa <= pci_req.addr;
      wr_q <= pci_req.write;
      mul_q <= pci_req.multiple;
    end
    if (pbus_req_valid && pbus_req_ready) begin
      pba <= pbus_req.addr;
      pbb <= pbus_req.bytes;
    end
  end
  a_read_txn_code: assert property (pbus_req_valid && !pbus_req.write
    |-> pbus_req.txn_code == shd[20:16]) else $error("read code wrong");
  a_write_txn_code: assert property (pbus_req_valid && pbus_req.write
    |-> pbus_req.txn_code == shd[12:8]) else $error("write code wrong");
  a_global_pin: assert property (pbus_req_valid
    |-> pbus_req.pbus_global_pin_n == shd[15]) else $error("global pin wrong");
  a_cache_pin: assert property (pbus_req_valid
    |-> pbus_req.pbus_cache_inhibit_pin_n == shd[14]) else $error("cache pin");
  a_plain_read_size: assert property (pbus_req_valid && !pbus_req.write
    && !mul_q && !shd[4] |-> pbus_req.bytes == 8'h08) else $error("size wrong");
  a_passthru_addr: assert property (pbus_req_valid && !shd[30]
    && shd[6:5] != 2'h1 |-> pbus_req.addr == pa) else $error("addr changed");
  a_write_answer: assert property (pci_rsp_valid && pci_rsp.claimed && wr_q
    |-> $past(pbus_req_valid && pbus_req_ready)) else $error("write not sent");
  a_miss_answer: assert property (pci_rsp_valid && !pci_rsp.claimed
    |-> $past(pci_req_valid && pci_req_ready, 2)) else $error("miss late");
  a_shell_fixed: assert property (pci_rsp_valid && pci_rsp.shell && !wr_q
    |-> pbb == 8'h08 && pba == pa) else $error("shell read altered");
  c_shell: cover property (pci_rsp_valid && pci_rsp.shell);
  c_miss: cover property (pci_rsp_valid && !pci_rsp.claimed);
  c_write: cover property (pbus_req_valid && pbus_req.write);
endmodule
bind mtw_ctl mtw_ctl_monitor i_mon (.clk(clk), .rst_n(rst_n),
  .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wdata(s_wdata), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .cfg_load(cfg_load), .cfg_bar_visible(cfg_bar_visible),
  .cfg_size_code(cfg_size_code), .pci_req_valid(pci_req_valid),
  .pci_req_ready(pci_req_ready), .pci_req(pci_req),
  .pci_rsp_valid(pci_rsp_valid), .pci_rsp(pci_rsp),
  .pbus_req_valid(pbus_req_valid), .pbus_req_ready(pbus_req_ready),
  .pbus_req(pbus_req));

// ==== tb/mtw_ctl_bench.sv ====
// self-checking bench for the message target window control block.
// assumes the bus model and bound monitor are compiled before it.
`timescale 1ns/1ns
module mtw_ctl_bench;
  logic                   clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [31:0]            s_awaddr = '0, s_wdata = '0, s_araddr = '0, rd;
  logic                   s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic                   s_arvalid = 0, s_rready = 0, s_awready, s_wready;
  logic [1:0]             s_bresp, s_rresp;
  logic                   s_bvalid, s_arready, s_rvalid, pci_req_ready;
  logic [31:0]            s_rdata, pbus_rd_data;
  logic                   cfg_load = 0, cfg_bar_visible = 0;
  logic [3:0]             cfg_size_code = '0;
  logic                   pci_req_valid = 0, pci_rsp_valid;
  logic                   pbus_req_valid, pbus_req_ready, pbus_rd_valid;
  mtw_pkg::mtw_pci_req_t  pci_req = '0;
  mtw_pkg::mtw_pci_rsp_t  pci_rsp, p;
  mtw_pkg::mtw_pbus_req_t pbus_req, pb;
  int                     pb_n, errors = 0, n_compared = 0;
  always #4 clk = ~clk;
  mtw_ctl i_dut (.clk(clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .cfg_load(cfg_load),
    .cfg_bar_visible(cfg_bar_visible), .cfg_size_code(cfg_size_code),
    .pci_req_valid(pci_req_valid), .pci_req_ready(pci_req_ready),
    .pci_req(pci_req), .pci_rsp_valid(pci_rsp_valid), .pci_rsp(pci_rsp),
    .pbus_req_valid(pbus_req_valid), .pbus_req_ready(pbus_req_ready),
    .pbus_req(pbus_req), .pbus_rd_valid(pbus_rd_valid),
    .pbus_rd_data(pbus_rd_data));
  mtw_pbus_model i_pb (.clk(clk), .rst_n(rst_n), .slow(slow),
    .pbus_req_valid(pbus_req_valid), .pbus_req(pbus_req),
    .pbus_req_ready(pbus_req_ready), .pbus_rd_valid(pbus_rd_valid),
    .pbus_rd_data(pbus_rd_data), .last_req(pb), .n_req(pb_n));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 500) begin
      errors++;
      $display("Error at %0t: handshake timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    s_awaddr <= {20'h0, a};
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 500);
    guard(n);
    chk(32'(s_bresp), 32'h0);
  endtask
  task automatic rdr(input logic [11:0] a, input logic [1:0] er);
    int n;
    s_araddr <= {20'h0, a};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 500);
    guard(n);
    rd = s_rdata;
    chk(32'(s_rresp), 32'(er));
  endtask
  task automatic pci(input logic w, input logic m, input logic [31:0] a);
    int n;
    logic t;
    pci_req <= '{w, m, a, 32'h5eed_0001, 4'hf};
    pci_req_valid <= 1'b1;
    t = 0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (t && pci_rsp_valid) break;
      if (pci_req_ready) t = 1;
      if (pci_req_ready) pci_req_valid <= 1'b0;
    end while (n < 500);
    guard(n);
    p = pci_rsp;
  endtask
  task automatic t_regs;
    rdr(12'h500, 2'h0);
    chk(rd, 32'h000a_0240);
    rdr(12'h0fc, 2'h2);
    chk(rd, 32'h0);
    rdr(12'h514, 2'h0);
    chk(rd, 32'h0);
    wr(12'h510, 32'h8000_0000);
    rdr(12'h510, 2'h0);
    chk(rd, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_enable;
    wr(12'h500, 32'h200a_0240);
    wr(12'h510, 32'h8000_0000);
    rdr(12'h510, 2'h0);
    chk(rd, 32'h8000_0000);
    rdr(12'h500, 2'h0);
    chk(32'(rd[31]), 32'h1);
    wr(12'h510, 32'h0);
    wr(12'h510, 32'h8000_0000);
    rdr(12'h500, 2'h0);
    chk(32'(rd[31]), 32'h0);
    pci(1'b1, 1'b0, 32'h8000_2000);
    chk(32'(p.claimed), 32'h0);
    wr(12'h500, 32'ha00a_0240);
    $display("enable test done");
  endtask
  task automatic t_write;
    pci(1'b1, 1'b0, 32'h8000_2000);
    chk(pb.addr, 32'h8000_2000);
    chk(32'(pb.txn_code), 32'h02);
    chk(pb.wdata, 32'h5eed_0001);
    chk(32'({pb.pbus_global_pin_n, pb.pbus_cache_inhibit_pin_n}), 0);
    wr(12'h504, 32'h1234_0000);
    wr(12'h500, 32'he00a_c240);
    pci(1'b1, 1'b0, 32'h8000_2000);
    chk(pb.addr, 32'h1234_2000);
    chk(32'({pb.pbus_global_pin_n, pb.pbus_cache_inhibit_pin_n}), 3);
    $display("write test done");
  endtask
  task automatic t_read;
    int n0;
    wr(12'h500, 32'ha00a_02d3);
    slow <= 1'b1;
    n0 = pb_n;
    pci(1'b0, 1'b0, 32'h8000_3000);
    chk(p.rdata, 32'h43c3_3000);
    chk(32'(pb.bytes), 32'd64);
    pci(1'b0, 1'b0, 32'h8000_3004);
    chk(p.rdata, 32'h43c3_3004);
    chk(pb_n, n0 + 1);
    pci(1'b0, 1'b0, 32'h8000_3100);
    pci(1'b0, 1'b0, 32'h8000_3008);
    chk(pb_n, n0 + 3);
    slow <= 1'b0;
    for (int c = 0; c < 6; c++) begin
      wr(12'h500, 32'ha00a_0240 | c);
      pci(1'b0, 1'b1, 32'h8000_4000);
      chk(32'(pb.bytes), (c < 5) ? 32'd8 << c : 32'd8);
    end
    pci(1'b0, 1'b0, 32'h8000_4100);
    chk(32'(pb.bytes), 32'd8);
    for (int e = 0; e < 4; e++) begin
      wr(12'h500, 32'ha00a_0200 | (e << 5));
      pci(1'b0, 1'b0, 32'h8000_5000);
      rd = (e == 1) ? 32'h43c3_5004 : 32'h43c3_5000;
      chk(p.rdata, (e == 0 || e == 3) ? {<<8{rd}} : rd);
    end
    $display("read test done");
  endtask
  task automatic t_shell;
    int n0;
    wr(12'h500, 32'he40a_02d4);
    pci(1'b0, 1'b0, 32'h8000_0100);
    n0 = pb_n;
    chk(32'({p.claimed, p.shell}), 3);
    chk(pb.addr, 32'h8000_0100);
    chk(32'(pb.bytes), 32'd8);
    pci(1'b0, 1'b0, 32'h8000_0104);
    chk(pb_n, n0 + 1);
    pci(1'b0, 1'b0, 32'h8000_1000);
    chk(32'({p.claimed, p.shell}), 2);
    chk(pb.addr, 32'h1230_1000);
    $display("shell test done");
  endtask
  task automatic cfg(input logic [3:0] s);
    cfg_bar_visible <= 1'b1;
    cfg_size_code <= s;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask
  task automatic t_size;
    wr(12'h500, 32'he00a_0240);
    cfg(4'h1);
    rdr(12'h500, 2'h0);
    chk(32'(rd[27:24]), 32'h1);
    pci(1'b1, 1'b0, 32'h8001_0000);
    chk(pb.addr, 32'h1235_0000);
    cfg(4'h0);
    pci(1'b1, 1'b0, 32'h8001_0000);
    chk(32'(p.claimed), 32'h0);
    cfg(4'hf);
    pci(1'b1, 1'b0, 32'hf000_0000);
    chk(pb.addr, 32'h7000_0000);
    $display("size test done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enable();
    t_write();
    t_read();
    t_shell();
    t_size();
    tally_and_finish();
  end
endmodule
